/* rtl/pmic_power_state_sequencer.sv */
// Power-state controller: states, sequencing, backup retention, charger, slew.
// Assumes supply comparators and pins are asynchronous; watchdog and OTP on pclk.
`default_nettype none
// Overview of operation
// - Six power states: no power, off, on, sleep, backup, program.
// - Regulator on/off sequencing runs across five timeslots.
// - EEPROM configuration, when present, wins over OTP values.
// - Sequence registers writable in off; used on next on command.
// - No power disables everything and returns all registers to reset values.
// - Off keeps RTC and registers, holds system reset low.
// - Off disables regulators; alive regulator only if configured.
// - Backup charger disabled whenever state is off.
// - On state makes all functions available.
// - Sleep entry and exit run a programmable regulator sequence.
// - Backup disables regulators, keeps RTC, scratch and clock mode, resets rest.
// - Selectable unclocked backup freezes the RTC.
// - No power follows the always-on supply below POR threshold.
// - Backup follows the always-on supply below reset threshold.
// - Program state entered or left only by key sequences.
// - Requests come from control interface, watchdog and on pin.
// - Transitions are timed sequences from OTP or EEPROM data.
// - Charger target voltage selectable, 2.5 V or 3.1 V.
// - Charger mode CC or CC/CV, current 100 to 400 uA.
// - Converter slews at programmable rate on write or pin.
module pmic_power_state_sequencer
   import pmic_seq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic supply_por_ok,
   input wire logic supply_reset_ok,
   input wire logic on_pin,
   input wire logic dvs_pin,
   input wire logic eeprom_valid,
   input wire logic [23:0] eeprom_slot_cfg,
   input wire logic [23:0] otp_slot_cfg,
   input wire logic wdog_req,
   input wire logic [1:0] wdog_cmd,
   output logic [2:0] power_state,
   output logic [7:0] reg_en,
   output logic alive_en,
   output logic sys_reset_n,
   output logic rtc_run,
   output logic charger_en,
   output logic charger_vsel,
   output logic charger_cccv,
   output logic [1:0] charger_ichg,
   output logic [6:0] dvs_level,
   output logic dvs_busy
);
   typedef struct packed {
      fsm_t fsm;
      logic [2:0] code;
      logic [7:0] reg_en;
      logic [7:0] elig;
      logic seq_start;
      logic seq_up;
      logic seq_abort;
      logic alive_en;
      logic sysrst_n;
      logic rtc_run;
      logic chg_en;
      logic [23:0] slot_cfg;
      logic [7:0] sleep_keep;
      logic [15:0] cfg;
      logic [31:0] scratch;
      logic key_armed;
      logic reject;
      logic src_ee;
      logic [6:0] dvs_level;
      logic [6:0] dvs_tgt;
      logic [7:0] dvs_rate;
      logic [7:0] dvs_cnt;
      logic dvs_busy;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [4:0] sync1;
      logic [4:0] sync2;
      logic [1:0] prev;
   } state_t;

   localparam state_t S_RST = '{fsm: F_NOPWR, cfg: CFG_RST, default: '0};

   state_t s_q, s_d;
   seq_if sq();
   logic acc, wr_en, mapped;
   logic por_s, rok_s, pin_s, dvp_s, eev_s;
   logic [31:0] rdata;

   // Regulators assigned to a given timeslot
   function automatic logic [7:0] slot_mask(input logic [23:0] cfg, input logic [2:0] slot);
      logic [7:0] m;
      m = '0;
      for (int i = 0; i < NUM_REGS; i++) begin
         m[i] = (cfg[i*3 +: 3] == slot);
      end
      return m;
   endfunction

   // Externally visible state code for each controller state
   function automatic logic [2:0] code_of(input fsm_t f);
      pwr_code_t c;
      unique case (f)
         F_NOPWR: c = PS_NO_POWER;
         F_BACKUP: c = PS_BACKUP;
         F_OFF, F_SEQ_UP: c = PS_OFF;
         F_ON, F_SEQ_SLP: c = PS_ON;
         F_SLEEP, F_SEQ_WAKE: c = PS_SLEEP;
         F_SEQ_DN: c = PS_ON;
         F_PROG: c = PS_PROGRAM;
      endcase
      return 3'(c);
   endfunction

   // Synchronised pin levels, read from the second stage only
   assign por_s = s_q.sync2[0];
   assign rok_s = s_q.sync2[1];
   assign pin_s = s_q.sync2[2];
   assign dvp_s = s_q.sync2[3];
   assign eev_s = s_q.sync2[4];

   // Transfer completes on the access cycle that sees pready high
   assign acc = psel & penable & s_q.pready;
   assign wr_en = acc & pwrite;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= ADDR_SCRATCH);

   // Read mux; reserved bits read zero
   always_comb begin
      rdata = '0;
      case (paddr)
         ADDR_STATUS: begin
            rdata[2:0] = s_q.code;
            rdata[ST_SEQ] = sq.busy;
            rdata[ST_EE] = s_q.src_ee;
            rdata[ST_REJ] = s_q.reject;
            rdata[ST_DVS] = s_q.dvs_busy;
         end
         ADDR_SLOT: rdata[23:0] = s_q.slot_cfg;
         ADDR_SLEEP: rdata[7:0] = s_q.sleep_keep;
         ADDR_CFG: rdata[15:0] = s_q.cfg;
         ADDR_DVS: rdata[15:0] = {s_q.dvs_rate, 1'b0, s_q.dvs_tgt};
         ADDR_SCRATCH: rdata = s_q.scratch;
         default: rdata = '0;
      endcase
   end

   // Whole controller next-state logic
   always_comb begin
      logic [1:0] req;
      logic [7:0] m;
      logic rej_set;
      logic rej_clr;
      logic pin_rise;
      logic dvs_rise;
      s_d = s_q;
      req = CMD_NONE;
      m = '0;
      rej_set = 1'b0;
      rej_clr = 1'b0;
      pin_rise = pin_s & ~s_q.prev[0];
      dvs_rise = dvp_s & ~s_q.prev[1];
      s_d.seq_start = 1'b0;
      s_d.seq_abort = 1'b0;

      // One wait state on every APB transfer
      s_d.pready = psel & penable & ~s_q.pready;
      s_d.pslverr = psel & penable & ~s_q.pready & ~mapped;
      if (psel & penable & ~s_q.pready) begin
         s_d.prdata = pwrite ? 32'h0000_0000 : rdata;
      end

      // Control interface first, then watchdog, then on pin
      if (wr_en && paddr == ADDR_CMD) begin
         req = pwdata[1:0];
      end else if (wdog_req) begin
         req = wdog_cmd;
      end else if (pin_rise) begin
         req = CMD_ON;
      end

      // Software register writes
      if (wr_en) begin
         unique case (paddr)
            ADDR_SLOT: if (s_q.fsm == F_OFF) s_d.slot_cfg = pwdata[23:0];
            ADDR_SLEEP: if (s_q.fsm == F_OFF) s_d.sleep_keep = pwdata[7:0];
            ADDR_CFG: s_d.cfg = pwdata[15:0];
            ADDR_SCRATCH: s_d.scratch = pwdata;
            ADDR_STATUS: rej_clr = pwdata[ST_REJ];
            default: ;
         endcase
      end

      // Slew start on a write or a pin edge, then step once per rate period
      if (wr_en && paddr == ADDR_DVS) begin
         s_d.dvs_tgt = pwdata[DVS_TGT +: 7];
         s_d.dvs_rate = pwdata[DVS_RATE +: 8];
         s_d.dvs_cnt = pwdata[DVS_RATE +: 8];
         s_d.dvs_busy = (pwdata[DVS_TGT +: 7] != s_q.dvs_level);
      end else if (dvs_rise) begin
         s_d.dvs_cnt = s_q.dvs_rate;
         s_d.dvs_busy = (s_q.dvs_tgt != s_q.dvs_level);
      end else if (s_q.dvs_busy) begin
         if (s_q.dvs_cnt != 8'h00) begin
            s_d.dvs_cnt = s_q.dvs_cnt - 8'h01;
         end else begin
            s_d.dvs_cnt = s_q.dvs_rate;
            s_d.dvs_level = (s_q.dvs_tgt > s_q.dvs_level) ?
               s_q.dvs_level + 7'h01 : s_q.dvs_level - 7'h01;
            s_d.dvs_busy = (s_d.dvs_level != s_q.dvs_tgt);
         end
      end

      // Slot entry switches that slot's regulators on or off
      if (sq.tick) begin
         m = slot_mask(s_q.slot_cfg, sq.slot) & s_q.elig;
         s_d.reg_en = s_q.seq_up ? (s_q.reg_en | m) : (s_q.reg_en & ~m);
      end

      // Program entry key pair, accepted only from off
      if (wr_en && paddr == ADDR_PROG) begin
         if (s_q.fsm == F_OFF && pwdata == PROG_KEY1) begin
            s_d.key_armed = 1'b1;
         end else if (s_q.fsm == F_OFF && s_q.key_armed && pwdata == PROG_KEY2) begin
            s_d.key_armed = 1'b0;
            s_d.fsm = F_PROG;
         end else if (s_q.fsm == F_PROG && pwdata == PROG_EXIT) begin
            s_d.fsm = F_OFF;
         end else begin
            s_d.key_armed = 1'b0;
            rej_set = 1'b1;
         end
      end else if (wr_en) begin
         s_d.key_armed = 1'b0;
      end

      // Power-state walk; supply conditions override all else
      unique case (s_q.fsm)
         F_NOPWR: s_d.fsm = F_BACKUP;
         F_BACKUP: begin
            s_d.slot_cfg = eev_s ? eeprom_slot_cfg : otp_slot_cfg;
            s_d.src_ee = eev_s;
            s_d.fsm = F_OFF;
         end
         F_OFF: begin
            if (req == CMD_ON && s_d.fsm == F_OFF) begin
               s_d.fsm = F_SEQ_UP;
               s_d.elig = 8'hff;
               s_d.seq_up = 1'b1;
               s_d.seq_start = 1'b1;
            end
         end
         F_SEQ_UP: if (sq.done) s_d.fsm = F_ON;
         F_ON: begin
            if (req == CMD_OFF) begin
               s_d.fsm = F_SEQ_DN;
               s_d.elig = 8'hff;
               s_d.seq_up = 1'b0;
               s_d.seq_start = 1'b1;
            end else if (req == CMD_SLEEP) begin
               s_d.fsm = F_SEQ_SLP;
               s_d.elig = ~s_q.sleep_keep;
               s_d.seq_up = 1'b0;
               s_d.seq_start = 1'b1;
            end
         end
         F_SEQ_SLP: if (sq.done) s_d.fsm = F_SLEEP;
         F_SLEEP: begin
            if (req == CMD_ON) begin
               s_d.fsm = F_SEQ_WAKE;
               s_d.elig = ~s_q.sleep_keep;
               s_d.seq_up = 1'b1;
               s_d.seq_start = 1'b1;
            end else if (req == CMD_OFF) begin
               s_d.fsm = F_SEQ_DN;
               s_d.elig = 8'hff;
               s_d.seq_up = 1'b0;
               s_d.seq_start = 1'b1;
            end
         end
         F_SEQ_WAKE: if (sq.done) s_d.fsm = F_ON;
         F_SEQ_DN: begin
            if (sq.done) begin
               s_d.fsm = F_OFF;
               s_d.reg_en = '0;
            end
         end
         F_PROG: s_d.reg_en = '0;
      endcase

      // Sticky reject flag; a new reject beats a clear in the same cycle
      s_d.reject = (s_q.reject & ~rej_clr) | rej_set;

      // Supply loss wipes state; scratch and clock mode survive backup
      if (!por_s) begin
         s_d = S_RST;
         s_d.seq_abort = 1'b1;
      end else if (!rok_s) begin
         s_d = S_RST;
         s_d.fsm = F_BACKUP;
         s_d.scratch = s_q.scratch;
         s_d.cfg[CFG_UNCLK] = s_q.cfg[CFG_UNCLK];
         s_d.seq_abort = 1'b1;
      end

      // Outputs derived from the state being entered
      s_d.code = code_of(s_d.fsm);
      s_d.sysrst_n = (s_d.fsm == F_ON) || (s_d.fsm == F_SLEEP) ||
         (s_d.fsm == F_SEQ_SLP) || (s_d.fsm == F_SEQ_WAKE);
      s_d.alive_en = (s_d.fsm == F_OFF) ? s_d.cfg[CFG_ALIVE] :
         (s_d.fsm != F_NOPWR && s_d.fsm != F_BACKUP && s_d.fsm != F_PROG);
      s_d.chg_en = s_d.cfg[CFG_CHG_EN] &&
         (s_d.fsm == F_ON || s_d.fsm == F_SLEEP);
      s_d.rtc_run = (s_d.fsm == F_NOPWR) ? 1'b0 :
         (s_d.fsm == F_BACKUP) ? ~s_d.cfg[CFG_UNCLK] : 1'b1;

      // Two-stage synchronisers; these survive any wipe
      s_d.sync1 = {eeprom_valid, dvs_pin, on_pin, supply_reset_ok, supply_por_ok};
      s_d.sync2 = s_q.sync1;
      s_d.prev = {dvp_s, pin_s};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= S_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Timeslot timer hookup
   assign sq.start = s_q.seq_start;
   assign sq.up = s_q.seq_up;
   assign sq.abort = s_q.seq_abort;
   assign sq.slot_len = s_q.cfg[CFG_SLOT_LEN +: 8];

   slot_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .t(sq.timer)
   );

   // Outputs straight from the state register
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign power_state = s_q.code;
   assign reg_en = s_q.reg_en;
   assign alive_en = s_q.alive_en;
   assign sys_reset_n = s_q.sysrst_n;
   assign rtc_run = s_q.rtc_run;
   assign charger_en = s_q.chg_en;
   assign charger_vsel = s_q.cfg[CFG_VSEL];
   assign charger_cccv = s_q.cfg[CFG_CCCV];
   assign charger_ichg = s_q.cfg[CFG_ICHG +: 2];
   assign dvs_level = s_q.dvs_level;
   assign dvs_busy = s_q.dvs_busy;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence seq_launch;
      s_q.fsm == F_OFF ##1 s_q.fsm == F_SEQ_UP;
   endsequence

   a_nopower_follow: assert property (!por_s |=> s_q.fsm == F_NOPWR)
      else $error("no power not entered on low supply");
   a_backup_follow: assert property (por_s && !rok_s |=> s_q.fsm == F_BACKUP)
      else $error("backup not entered on supply below reset level");
   a_off_outputs: assert property (s_q.fsm == F_OFF |->
      !s_q.sysrst_n && s_q.reg_en == 8'h00 && !s_q.chg_en)
      else $error("off state outputs wrong");
   a_prog_from_off: assert property (s_q.fsm == F_PROG && $past(s_q.fsm) != F_PROG
      |-> $past(s_q.fsm) == F_OFF)
      else $error("program state entered from other than off");
   a_eeprom_wins: assert property (s_q.fsm == F_BACKUP && por_s && rok_s && eev_s
      |=> s_q.slot_cfg == $past(eeprom_slot_cfg) && s_q.src_ee)
      else $error("eeprom configuration not taken");
   a_unclocked_rtc: assert property (s_q.fsm == F_BACKUP && s_q.cfg[CFG_UNCLK]
      |-> !s_q.rtc_run)
      else $error("rtc runs in unclocked backup");
   a_seq_launch: assert property (seq_launch |-> s_q.seq_start ##1 sq.busy)
      else $error("power-up sequence not launched");
   a_sleep_keep: assert property (s_q.fsm == F_SEQ_SLP && sq.tick && rok_s && por_s
      |=> (s_q.reg_en & s_q.sleep_keep) == ($past(s_q.reg_en) & s_q.sleep_keep))
      else $error("kept regulator changed on sleep entry");
   a_supply_abort: assert property (sq.busy && !rok_s |=> s_q.seq_abort ##1 !sq.busy)
      else $error("sequence not aborted on supply loss");
   a_dvs_start: assert property (wr_en && paddr == ADDR_DVS && pwdata[6:0] != s_q.dvs_level
      && por_s && rok_s |=> s_q.dvs_busy)
      else $error("slew not started by write");
endmodule // pmic_power_state_sequencer
`default_nettype wire

/* rtl/pmic_seq_pkg.sv */
// Shared constants and types of the power-state sequencer.
// Assumes a single 100 MHz pclk domain and an APB register port.
`default_nettype none
package pmic_seq_pkg;
   // Register byte offsets on APB
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_PROG = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_SLOT = 8'h0c;
   localparam logic [7:0] ADDR_SLEEP = 8'h10;
   localparam logic [7:0] ADDR_CFG = 8'h14;
   localparam logic [7:0] ADDR_DVS = 8'h18;
   localparam logic [7:0] ADDR_SCRATCH = 8'h1c;
   localparam int NUM_SLOTS = 5;
   localparam int NUM_REGS = 8;
   // Power-state request codes
   localparam logic [1:0] CMD_NONE = 2'h0;
   localparam logic [1:0] CMD_OFF = 2'h1;
   localparam logic [1:0] CMD_ON = 2'h2;
   localparam logic [1:0] CMD_SLEEP = 2'h3;
   // Program-state keys, values arbitrary
   localparam logic [31:0] PROG_KEY1 = 32'h0000_a5c3;
   localparam logic [31:0] PROG_KEY2 = 32'h0000_3c5a;
   localparam logic [31:0] PROG_EXIT = 32'h0000_e11e;
   // Configuration register fields
   localparam int CFG_ALIVE = 0;
   localparam int CFG_UNCLK = 1;
   localparam int CFG_VSEL = 2;
   localparam int CFG_CCCV = 3;
   localparam int CFG_ICHG = 4;
   localparam int CFG_CHG_EN = 6;
   localparam int CFG_SLOT_LEN = 8;
   localparam logic [15:0] CFG_RST = 16'h1000;
   // Status register fields
   localparam int ST_SEQ = 3;
   localparam int ST_EE = 4;
   localparam int ST_REJ = 5;
   localparam int ST_DVS = 6;
   // Slew register fields
   localparam int DVS_TGT = 0;
   localparam int DVS_RATE = 8;
   typedef enum logic [2:0] {
      PS_NO_POWER, PS_OFF, PS_ON, PS_SLEEP, PS_BACKUP, PS_PROGRAM
   } pwr_code_t;
   typedef enum logic [3:0] {
      F_NOPWR, F_BACKUP, F_OFF, F_SEQ_UP, F_ON, F_SEQ_SLP, F_SLEEP,
      F_SEQ_WAKE, F_SEQ_DN, F_PROG
   } fsm_t;
endpackage
`default_nettype wire

/* rtl/seq_if.sv */
// Handshake between the state controller and the timeslot timer.
// Assumes both ends run on pclk.
`default_nettype none
interface seq_if;
   logic start;
   logic up;
   logic abort;
   logic [7:0] slot_len;
   logic [2:0] slot;
   logic busy;
   logic tick;
   logic done;
   modport ctrl(output start, up, abort, slot_len, input slot, busy, tick, done);
   modport timer(input start, up, abort, slot_len, output slot, busy, tick, done);
endinterface
`default_nettype wire

/* rtl/slot_timer.sv */
// Timeslot timer: walks slots 1..5 upward or 5..1 downward.
// Assumes start is a one-cycle pulse from the controller on pclk.
`default_nettype none
module slot_timer
   import pmic_seq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   seq_if.timer t
);
   typedef struct packed {
      logic busy;
      logic up;
      logic [2:0] slot;
      logic [7:0] cnt;
      logic tick;
      logic done;
   } tmr_t;
   localparam logic [2:0] LAST_UP = 3'(NUM_SLOTS);
   tmr_t s_q, s_d;

   // Each slot lasts slot_len+1 cycles; tick marks a slot's first cycle
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      s_d.done = 1'b0;
      if (t.abort) begin
         s_d.busy = 1'b0;
      end else if (t.start) begin
         s_d.busy = 1'b1;
         s_d.up = t.up;
         s_d.slot = t.up ? 3'h1 : LAST_UP;
         s_d.cnt = t.slot_len;
         s_d.tick = 1'b1;
      end else if (s_q.busy) begin
         if (s_q.cnt != 8'h00) begin
            s_d.cnt = s_q.cnt - 8'h01;
         end else if (s_q.slot == (s_q.up ? LAST_UP : 3'h1)) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end else begin
            s_d.slot = s_q.up ? s_q.slot + 3'h1 : s_q.slot - 3'h1;
            s_d.cnt = t.slot_len;
            s_d.tick = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign t.busy = s_q.busy;
   assign t.slot = s_q.slot;
   assign t.tick = s_q.tick;
   assign t.done = s_q.done;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_slot_range: assert property (s_q.busy |-> s_q.slot >= 3'h1 && s_q.slot <= LAST_UP)
      else $error("timeslot out of range");
endmodule // slot_timer
`default_nettype wire

/* verification/eeprom_model.sv */
// External configuration EEPROM model on the sequencer's config inputs.
// Assumes the bench drives attach in the pclk domain.
`default_nettype none
module eeprom_model #(
   parameter logic [23:0] CONTENTS = 24'h000009
) (
   input wire logic pclk,
   input wire logic attach,
   output logic present,
   output logic [23:0] slot_cfg
);
   timeunit 1ns;
   timeprecision 1ns;
   logic present_q = 1'b0;
   logic [23:0] data_q = CONTENTS;
   // A detached part leaves its lines floating, so show a toggling pattern
   always @(posedge pclk) begin
      present_q <= attach;
      data_q <= attach ? CONTENTS : ~data_q;
   end
   assign present = present_q;
   assign slot_cfg = data_q;
endmodule // eeprom_model
`default_nettype wire

/* verification/pmic_power_state_sequencer_tb_top.sv */
// Self-checking bench: APB host tasks and one task per scenario.
// Assumes the design package and the EEPROM model are compiled first.
`default_nettype none
module pmic_power_state_sequencer_tb_top
   import pmic_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [23:0] OTP_CFG = 24'h000018;
   localparam logic [23:0] EE_CFG = 24'h000009;
   localparam logic [31:0] HOST_SLOT = 32'h0060_0151;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er;
   logic supply_por_ok = 1'b1, supply_reset_ok = 1'b1, on_pin = 1'b0, dvs_pin = 1'b0;
   logic ee_attach = 1'b1, wdog_req = 1'b0, eeprom_valid;
   logic [1:0] wdog_cmd = 2'h0;
   logic [23:0] eeprom_slot_cfg;
   logic [2:0] power_state;
   logic [7:0] reg_en;
   logic alive_en, sys_reset_n, rtc_run, charger_en, charger_vsel, charger_cccv, dvs_busy;
   logic [1:0] charger_ichg;
   logic [6:0] dvs_level;
   int failures = 0;
   int n_tests = 0;

   pmic_power_state_sequencer u_pmic_power_state_sequencer (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_por_ok(supply_por_ok), .supply_reset_ok(supply_reset_ok), .on_pin(on_pin),
      .dvs_pin(dvs_pin), .eeprom_valid(eeprom_valid), .eeprom_slot_cfg(eeprom_slot_cfg),
      .otp_slot_cfg(OTP_CFG), .wdog_req(wdog_req), .wdog_cmd(wdog_cmd),
      .power_state(power_state), .reg_en(reg_en), .alive_en(alive_en),
      .sys_reset_n(sys_reset_n), .rtc_run(rtc_run), .charger_en(charger_en),
      .charger_vsel(charger_vsel), .charger_cccv(charger_cccv),
      .charger_ichg(charger_ichg), .dvs_level(dvs_level), .dvs_busy(dvs_busy)
   );
   eeprom_model #(.CONTENTS(EE_CFG)) u_eeprom_model (
      .pclk(pclk), .attach(ee_attach), .present(eeprom_valid), .slot_cfg(eeprom_slot_cfg)
   );

   // 100 MHz clock
   initial begin
      forever #5 pclk = ~pclk;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; a slave that never answers ends the run
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         failures++;
         stop_test();
      end
   endtask

   task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, rd, exp);
   endtask

   // Bounded wait for a power state; sequences take tens of cycles at most
   task automatic wait_st(input pwr_code_t s);
      int n;
      n = 0;
      while (power_state !== s && n < 500) begin
         @(posedge pclk);
         n++;
      end
      chk("power_state", {29'h0, power_state}, {29'h0, s});
      if (n >= 500) begin
         stop_test();
      end
   endtask

   task automatic boot_off();
      wait_st(PS_OFF);
      chk("sys_reset_n", sys_reset_n, 0);
      chk("rtc_run", rtc_run, 1);
      chk("reg_en", reg_en, 0);
      chk("alive_en", alive_en, 0);
      rdchk("status", ADDR_STATUS, 32'h11);
      rdchk("slot", ADDR_SLOT, {8'h0, EE_CFG});
      rdchk("cfg", ADDR_CFG, {16'h0, CFG_RST});
      apb(1'b0, 8'h20, 32'h0);
      chk("pslverr", er, 1);
      chk("unmapped", rd, 0);
      apb(1'b1, ADDR_CFG, 32'h0000_026f);
      repeat (2) @(posedge pclk);
      chk("alive_en", alive_en, 1);
      chk("charger_en", charger_en, 0);
      chk("vsel", charger_vsel, 1);
      chk("cccv", charger_cccv, 1);
      chk("ichg", charger_ichg, 2);
      apb(1'b1, ADDR_SLEEP, 32'h01);
      apb(1'b1, ADDR_SLOT, HOST_SLOT);
      apb(1'b1, ADDR_CMD, CMD_ON);
      wait_st(PS_ON);
      chk("reg_en", reg_en, 8'h87);
      chk("sys_reset_n", sys_reset_n, 1);
      chk("charger_en", charger_en, 1);
   endtask

   task automatic sleep_wake();
      int n;
      n = 0;
      // Keep mask is locked outside off, so this write must not land
      apb(1'b1, ADDR_SLEEP, 32'h02);
      rdchk("sleep", ADDR_SLEEP, 32'h01);
      apb(1'b1, ADDR_CMD, CMD_SLEEP);
      wait_st(PS_SLEEP);
      chk("reg_en", reg_en, 8'h01);
      @(posedge pclk);
      on_pin <= 1'b1;
      wait_st(PS_ON);
      on_pin <= 1'b0;
      chk("reg_en", reg_en, 8'h87);
      // Slew to level 5 at one step per two cycles
      apb(1'b1, ADDR_DVS, 32'h0000_0105);
      // Busy rises on the edge that completes the write, so let it settle first
      @(posedge pclk);
      chk("dvs_busy", dvs_busy, 1);
      while (dvs_busy !== 1'b0 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk("dvs_timeout", n < 200, 1);
      chk("dvs_level", dvs_level, 5);
   endtask

   task automatic wdog_off();
      @(posedge pclk);
      wdog_req <= 1'b1;
      wdog_cmd <= CMD_OFF;
      @(posedge pclk);
      wdog_req <= 1'b0;
      wait_st(PS_OFF);
      chk("reg_en", reg_en, 0);
      chk("sys_reset_n", sys_reset_n, 0);
      chk("charger_en", charger_en, 0);
   endtask

   task automatic program_keys();
      apb(1'b1, ADDR_PROG, 32'h1234);
      rdchk("status", ADDR_STATUS, 32'h31);
      apb(1'b1, ADDR_STATUS, 32'h20);
      rdchk("status", ADDR_STATUS, 32'h11);
      apb(1'b1, ADDR_PROG, PROG_KEY1);
      apb(1'b1, ADDR_PROG, PROG_KEY2);
      wait_st(PS_PROGRAM);
      apb(1'b1, ADDR_CMD, CMD_ON);
      repeat (3) @(posedge pclk);
      chk("prog_hold", power_state, PS_PROGRAM);
      apb(1'b1, ADDR_PROG, PROG_EXIT);
      wait_st(PS_OFF);
   endtask

   task automatic supply_loss();
      apb(1'b1, ADDR_SCRATCH, 32'h5a5a_0f0f);
      apb(1'b1, ADDR_CMD, CMD_ON);
      repeat (4) @(posedge pclk);
      supply_reset_ok <= 1'b0;
      wait_st(PS_BACKUP);
      chk("reg_en", reg_en, 0);
      chk("rtc_run", rtc_run, 0);
      @(posedge pclk);
      supply_reset_ok <= 1'b1;
      wait_st(PS_OFF);
      rdchk("scratch", ADDR_SCRATCH, 32'h5a5a_0f0f);
      rdchk("cfg", ADDR_CFG, 32'h1002);
      rdchk("slot", ADDR_SLOT, {8'h0, EE_CFG});
      @(posedge pclk);
      ee_attach <= 1'b0;
      supply_por_ok <= 1'b0;
      wait_st(PS_NO_POWER);
      chk("rtc_run", rtc_run, 0);
      chk("reg_en", reg_en, 0);
      @(posedge pclk);
      supply_por_ok <= 1'b1;
      wait_st(PS_OFF);
      rdchk("scratch", ADDR_SCRATCH, 32'h0);
      rdchk("slot", ADDR_SLOT, {8'h0, OTP_CFG});
      rdchk("status", ADDR_STATUS, 32'h01);
   endtask

   // Reset for five cycles, then the scenarios in order
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      boot_off();
      sleep_wake();
      wdog_off();
      program_keys();
      supply_loss();
      stop_test();
   end
endmodule // pmic_power_state_sequencer_tb_top
`default_nettype wire
